// file: rfks_freq_counter.sv
// rfks_freq_counter.sv: prescaler and gated saturating counter for the rf drive
`timescale 1ns/10ps
`default_nettype none
module rfks_freq_counter #(
  parameter int unsigned COUNT_W = 12,
  parameter int unsigned DIV     = 64
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               rf_edge,
  input  wire logic               gate_en,
  input  wire logic               count_clear,
  output logic      [COUNT_W-1:0] count_q
);
  import rfks_pkg::*;

  if (DIV < 2 || (DIV & (DIV - 1)) != 0) begin : g_bad_div
    $error("prescaler divide must be a power of two");
  end

  localparam int unsigned PW = $clog2(DIV);

  logic [PW-1:0]      pre_q;
  logic [PW-1:0]      pre_d;
  logic               pre_tick;
  logic [COUNT_W-1:0] count_d;

  // ==================================================================
  // prescaler and counter
  always_comb begin
    pre_d    = pre_q;
    pre_tick = 1'b0;
    count_d  = count_q;
    if (rf_edge) begin
      pre_d    = pre_q + 1'b1;
      pre_tick = (pre_q == PW'(DIV - 1));
    end
    if (count_clear) begin
      count_d = '0;
      pre_d   = '0;
    end else if (gate_en && pre_tick && count_q != '1) begin
      count_d = count_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pre_q   <= '0;
      count_q <= '0;
    end else begin
      pre_q   <= pre_d;
      count_q <= count_d;
    end
  end

endmodule : rfks_freq_counter
`default_nettype wire

// file: rfks_pkg.sv
// rfks_pkg.sv: constants and types for the rf key sequencer and band select block
package rfks_pkg;

  // ==================================================================
  // clock and timing
  localparam int unsigned CLK_HZ            = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned KEY_DELAY_MS      = 20;
  localparam int unsigned KEY_DELAY_CYC     = (KEY_DELAY_MS * 1_000_000) / CLK_PERIOD_NS;
  localparam int unsigned DIVIDER_STAGES    = 12;
  localparam int unsigned GATE_CLOCK_HZ     = 3204;
  // crystal rate that a 12-stage divider turns into the gate clock
  localparam int unsigned XTAL_HZ           = GATE_CLOCK_HZ * (2 ** DIVIDER_STAGES);
  localparam int unsigned GATE_PERIOD_CYC   = CLK_HZ / GATE_CLOCK_HZ;
  localparam int unsigned RELAY_STEP_CYC    = 16;
  localparam int unsigned SUPPLY_HOLD_CYC   = 2 * KEY_DELAY_CYC;
  localparam int unsigned CLOCK_LOSS_CYC    = 4 * GATE_PERIOD_CYC;

  // ==================================================================
  // counter and band layout
  localparam int unsigned PRESCALE_DIV      = 64;
  localparam int unsigned COUNT_W           = 12;
  localparam int unsigned BAND_N            = 4;
  localparam int unsigned RELAY_W           = 2 * BAND_N;
  // window of one gate period: count = f / 64 / 3204 (about 146 at 30 MHz)
  localparam logic [COUNT_W-1:0] BAND1_TOP  = 12'h0C2;
  localparam logic [COUNT_W-1:0] BAND2_TOP  = 12'h0FD;
  localparam logic [COUNT_W-1:0] BAND3_TOP  = 12'h14B;
  localparam logic [RELAY_W-1:0] RELAY_NONE = 8'h00;

  // ==================================================================
  // carriers
  typedef struct packed {
    logic antenna_output_relay;
    logic drive_input_relay;
    logic relay_supply;
  } rfks_key_t;

  typedef struct packed {
    logic [RELAY_W-1:0] relays;
    logic [1:0]         band;
    logic               valid;
  } rfks_band_t;

endpackage : rfks_pkg

// file: rfks_top.sv
// rfks_top.sv: rf keying sequencer with frequency based filter band select
`timescale 1ns/10ps
`default_nettype none
module rfks_top #(
  parameter int unsigned KEY_DELAY  = rfks_pkg::KEY_DELAY_CYC,
  parameter int unsigned GATE_CYC   = rfks_pkg::GATE_PERIOD_CYC,
  parameter int unsigned LOSS_CYC   = rfks_pkg::CLOCK_LOSS_CYC,
  parameter int unsigned SUPPLY_CYC = rfks_pkg::SUPPLY_HOLD_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 rf_present,
  input  wire logic                 direction_forward,
  input  wire logic                 rf_sample,
  input  wire logic                 crystal_tick,
  output var  rfks_pkg::rfks_key_t  key_q,
  output var  rfks_pkg::rfks_band_t band_q,
  output var  logic                 clock_lost_q
);
  import rfks_pkg::*;

  if (GATE_CYC < 8 || KEY_DELAY < 4 * GATE_CYC || LOSS_CYC <= GATE_CYC || SUPPLY_CYC < KEY_DELAY) begin : g_bad_timing
    $error("timing parameters inconsistent");
  end

  // ==================================================================
  // pin synchronisers: three stages, change counts when last two agree
  logic [2:0] s_pres_q, s_dir_q, s_rf_q, s_xt_q;
  logic       pres_q, dir_q, rf_q, xt_q;
  logic       pres_d, dir_d, rf_d, xt_d;
  logic       rf_edge, xt_edge;

  always_comb begin
    pres_d = (s_pres_q[1] == s_pres_q[2]) ? s_pres_q[2] : pres_q;
    dir_d  = (s_dir_q[1] == s_dir_q[2]) ? s_dir_q[2] : dir_q;
    rf_d   = (s_rf_q[1] == s_rf_q[2]) ? s_rf_q[2] : rf_q;
    xt_d   = (s_xt_q[1] == s_xt_q[2]) ? s_xt_q[2] : xt_q;
    rf_edge = rf_d & ~rf_q;
    xt_edge = xt_d & ~xt_q;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_pres_q <= '0;
      s_dir_q  <= '0;
      s_rf_q   <= '0;
      s_xt_q   <= '0;
      pres_q   <= 1'b0;
      dir_q    <= 1'b0;
      rf_q     <= 1'b0;
      xt_q     <= 1'b0;
    end else begin
      s_pres_q <= {s_pres_q[1:0], rf_present};
      s_dir_q  <= {s_dir_q[1:0], direction_forward};
      s_rf_q   <= {s_rf_q[1:0], rf_sample};
      s_xt_q   <= {s_xt_q[1:0], crystal_tick};
      pres_q   <= pres_d;
      dir_q    <= dir_d;
      rf_q     <= rf_d;
      xt_q     <= xt_d;
    end
  end

  // ==================================================================
  // gate clock, timing one-shot pair, clock-loss monitor
  logic [DIVIDER_STAGES-1:0] div_q, div_d;
  logic                      gate_tick;
  logic [31:0]               tim_q, tim_d;
  logic                      win_a, win_b;
  logic [31:0]               loss_q, loss_d;
  logic                      lost_d;

  always_comb begin
    div_d     = div_q;
    gate_tick = 1'b0;
    if (xt_edge) begin
      div_d     = div_q + 1'b1;
      gate_tick = (div_q == '1);
    end
    tim_d = (gate_tick) ? 32'h0000_0000 : ((tim_q < GATE_CYC) ? tim_q + 32'h0000_0001 : tim_q);
    win_a = (tim_q >= 32'h0000_0002) && (tim_q < GATE_CYC - 32'h0000_0004);
    win_b = (tim_q < 32'h0000_0002);
    loss_d = (gate_tick) ? 32'h0000_0000 : ((loss_q < LOSS_CYC) ? loss_q + 32'h0000_0001 : loss_q);
    lost_d = (loss_d >= LOSS_CYC);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_q        <= '0;
      tim_q        <= GATE_CYC;
      loss_q       <= 32'h0000_0000;
      clock_lost_q <= 1'b0;
    end else begin
      div_q        <= div_d;
      tim_q        <= tim_d;
      loss_q       <= loss_d;
      clock_lost_q <= lost_d;
    end
  end

  // ==================================================================
  // frequency counter
  logic [COUNT_W-1:0] count;
  logic               count_clear;

  assign count_clear = win_b & ~win_a;

  rfks_freq_counter #(
    .COUNT_W (COUNT_W),
    .DIV     (PRESCALE_DIV)
  ) u_counter (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .rf_edge     (rf_edge),
    .gate_en     (win_a),
    .count_clear (count_clear),
    .count_q     (count)
  );

  // ==================================================================
  // band lookup: one latching relay per band, set coil and reset coil
  function automatic rfks_band_t band_lookup(input logic [COUNT_W-1:0] c);
    logic [1:0] b;
    b = 2'h0;
    if (c > BAND3_TOP) begin
      b = 2'h3;
    end else if (c > BAND2_TOP) begin
      b = 2'h2;
    end else if (c > BAND1_TOP) begin
      b = 2'h1;
    end
    band_lookup.band  = b;
    band_lookup.valid = 1'b1;
    for (int i = 0; i < BAND_N; i++) begin
      band_lookup.relays[2*i]   = (b == i[1:0]);
      band_lookup.relays[2*i+1] = (b != i[1:0]);
    end
  endfunction : band_lookup

  // ==================================================================
  // keying: one-shots and relay sequence
  typedef enum logic [1:0] {RFKS_IDLE, RFKS_DELAY, RFKS_OUT_ON, RFKS_BOTH_ON} rfks_state_t;
  rfks_state_t state_q, state_d;
  logic [31:0] dly_q, dly_d;
  logic [31:0] sup_q, sup_d;
  rfks_key_t   key_d;
  rfks_band_t  band_d;
  logic        qualified, keying_pulse;

  always_comb begin
    qualified    = pres_q & dir_q;
    state_d      = state_q;
    dly_d        = dly_q;
    keying_pulse = (sup_q != 32'h0000_0000);
    sup_d = qualified ? SUPPLY_CYC : ((sup_q != 32'h0000_0000) ? sup_q - 32'h0000_0001 : sup_q);
    band_d = band_q;
    // latch on timing window end and keying
    // lookup drives relay word
    // closed window's count still stands at the first cycle; the clear lands one edge later
    if (win_b && keying_pulse && tim_q == 32'h0000_0000) begin
      band_d = band_lookup(count);
    end
    if (!qualified || clock_lost_q) begin
      state_d = RFKS_IDLE;
      dly_d   = 32'h0000_0000;
    end else begin
      unique case (state_q)
        RFKS_IDLE: begin
          state_d = RFKS_DELAY;
          dly_d   = 32'h0000_0000;
        end
        RFKS_DELAY: begin
          dly_d = dly_q + 32'h0000_0001;
          // wait for a latched band too
          if (dly_q >= KEY_DELAY - 32'h0000_0001 && band_q.valid) begin
            state_d = RFKS_OUT_ON;
            dly_d   = 32'h0000_0000;
          end
        end
        RFKS_OUT_ON: begin
          dly_d = dly_q + 32'h0000_0001;
          if (dly_q >= RELAY_STEP_CYC - 1) begin
            state_d = RFKS_BOTH_ON;
          end
        end
        RFKS_BOTH_ON: begin
          state_d = RFKS_BOTH_ON;
        end
      endcase
    end
    key_d.antenna_output_relay = (state_d == RFKS_OUT_ON) || (state_d == RFKS_BOTH_ON);
    key_d.drive_input_relay    = (state_d == RFKS_BOTH_ON);
    key_d.relay_supply         = (sup_d != 32'h0000_0000);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= RFKS_IDLE;
      dly_q   <= 32'h0000_0000;
      sup_q   <= 32'h0000_0000;
      key_q   <= '0;
      band_q  <= '{relays: RELAY_NONE, band: 2'h0, valid: 1'b0};
    end else begin
      state_q <= state_d;
      dly_q   <= dly_d;
      sup_q   <= sup_d;
      key_q   <= key_d;
      band_q  <= band_d;
    end
  end

  // ==================================================================
  // checks
  // input relay stays open for a while after the output relay closes
  sequence s_input_held_off;
    ~key_q.drive_input_relay [*8];
  endsequence

  property p_forward_only;
    @(posedge clk_sys) disable iff (reset) $rose(key_q.antenna_output_relay) |-> $past(qualified);
  endproperty
  a_forward_only: assert property (p_forward_only) else $error("keyed without forward drive");

  property p_delay;
    @(posedge clk_sys) disable iff (reset) $rose(key_q.antenna_output_relay) |->
      dly_q == 32'h0000_0000 && $past(state_q) == RFKS_DELAY && $past(dly_q) >= KEY_DELAY - 32'h0000_0001;
  endproperty
  a_delay: assert property (p_delay) else $error("output relay without delay");

  property p_order;
    @(posedge clk_sys) disable iff (reset) $rose(key_q.drive_input_relay) |-> $past(key_q.antenna_output_relay);
  endproperty
  a_order: assert property (p_order) else $error("input relay before output relay");

  property p_out_lead;
    @(posedge clk_sys) disable iff (reset) $rose(key_q.antenna_output_relay) |-> s_input_held_off;
  endproperty
  a_out_lead: assert property (p_out_lead) else $error("input relay too soon after output relay");

  property p_in_needs_out;
    @(posedge clk_sys) disable iff (reset) key_q.drive_input_relay |-> key_q.antenna_output_relay;
  endproperty
  a_in_needs_out: assert property (p_in_needs_out) else $error("input relay alone");

  property p_supply;
    @(posedge clk_sys) disable iff (reset) qualified |=> key_q.relay_supply;
  endproperty
  a_supply: assert property (p_supply) else $error("relay supply off during drive");

  property p_clear;
    @(posedge clk_sys) disable iff (reset) $past(count_clear) |-> count == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");

  property p_latch;
    @(posedge clk_sys) disable iff (reset) band_q != $past(band_q) |-> $past(keying_pulse) && $past(win_b);
  endproperty
  a_latch: assert property (p_latch) else $error("band latch loaded off window");

  property p_loss_hold;
    @(posedge clk_sys) disable iff (reset) clock_lost_q |=> ~key_q.antenna_output_relay && dly_q == 32'h0000_0000;
  endproperty
  a_loss_hold: assert property (p_loss_hold) else $error("keying while clock lost");

  property p_monitor;
    @(posedge clk_sys) disable iff (reset) gate_tick |=> ~clock_lost_q [*2];
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor set despite gate pulse");

endmodule : rfks_top
`default_nettype wire

// file: rfks_top_tb.sv
// rfks_top_tb.sv: self-checking bench for the rf keying sequencer
`timescale 1ns/10ps
`default_nettype none
module rfks_top_tb;
  import rfks_pkg::*;
  // ==================================================================
  // shortened counts; a gate tick comes every 16384 cycles here
  localparam int unsigned KD   = 10000;
  localparam int unsigned GC   = 64;
  localparam int unsigned LC   = 20000;
  localparam int unsigned SC   = 10000;
  localparam int unsigned CEIL = 100000;
  logic       clk_sys;
  logic       reset;
  logic       drive_on;
  logic       reflected;
  logic       xtal_run;
  logic       rf_present;
  logic       direction_forward;
  logic       rf_sample;
  logic       crystal_tick;
  rfks_key_t  key_q;
  rfks_band_t band_q;
  logic       clock_lost_q;
  int         n_fail;
  int         n_tests;
  int         cyc = 0;

  rfks_top #(.KEY_DELAY(KD), .GATE_CYC(GC), .LOSS_CYC(LC), .SUPPLY_CYC(SC)) dut (
    .clk_sys(clk_sys), .reset(reset), .rf_present(rf_present),
    .direction_forward(direction_forward), .rf_sample(rf_sample),
    .crystal_tick(crystal_tick), .key_q(key_q), .band_q(band_q), .clock_lost_q(clock_lost_q));

  rfks_xcvr_model xcvr (
    .clk_sys(clk_sys), .drive_on(drive_on), .reflected(reflected), .xtal_run(xtal_run),
    .rf_present(rf_present), .direction_forward(direction_forward),
    .rf_sample(rf_sample), .crystal_tick(crystal_tick));

  // ==================================================================
  // clock, timeout and reporting
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check1(input logic got, input logic exp, input string msg);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR %0t: %s got %b", $time, msg, got);
    end
  endtask : check1
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check8
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cycles

  // ==================================================================
  // scenarios
  task automatic t_reset();
    check1(key_q !== 3'b000, 1'b0, "key outputs after reset");
    check1(band_q.valid, 1'b0, "band valid after reset");
    check1(clock_lost_q, 1'b0, "clock lost after reset");
  endtask : t_reset

  // antenna pickup must never key the amplifier
  task automatic t_reflected();
    logic seen;
    seen = 1'b0;
    reflected = 1'b1;
    repeat (KD + 200) begin
      cycles(1);
      seen = seen | key_q.antenna_output_relay | key_q.drive_input_relay | key_q.relay_supply;
    end
    check1(seen, 1'b0, "keyed on reflected energy");
    reflected = 1'b0;
    cycles(10);
  endtask : t_reflected

  task automatic t_key();
    int t;
    drive_on = 1'b1;
    t = 0;
    while (key_q.relay_supply !== 1'b1 && t < 20) begin
      cycles(1);
      t++;
    end
    check1(key_q.relay_supply, 1'b1, "relay supply on drive");
    t = 0;
    while (key_q.antenna_output_relay !== 1'b1 && t < 40000) begin
      check1(key_q.drive_input_relay, 1'b0, "input relay before output");
      cycles(1);
      t++;
    end
    check1(t >= KD, 1'b1, "output relay before delay");
    check1(key_q.antenna_output_relay, 1'b1, "output relay never closed");
    check1(band_q.valid, 1'b1, "band not latched before keying");
    check1(band_q.band == 2'd0, 1'b1, "band for low count");
    check8(band_q.relays, 8'hA9, "filter relay word");
    check1(clock_lost_q, 1'b0, "monitor active with clock running");
    t = 0;
    while (key_q.drive_input_relay !== 1'b1 && t < 40) begin
      cycles(1);
      t++;
    end
    check1(t >= RELAY_STEP_CYC - 1 && t <= RELAY_STEP_CYC + 1, 1'b1, "input relay step");
    drive_on = 1'b0;
    cycles(8);
    check1(key_q.antenna_output_relay | key_q.drive_input_relay, 1'b0, "relays after drop");
    check1(key_q.relay_supply, 1'b1, "supply held after drop");
    cycles(SC + 10);
    check1(key_q.relay_supply, 1'b0, "supply after hold");
  endtask : t_key

  // a dead crystal must block both relays
  task automatic t_loss();
    int   t;
    logic seen;
    xtal_run = 1'b0;
    t = 0;
    while (clock_lost_q !== 1'b1 && t < LC + 9000) begin
      cycles(1);
      t++;
    end
    check1(clock_lost_q, 1'b1, "clock loss not flagged");
    drive_on = 1'b1;
    seen = 1'b0;
    repeat (KD + 200) begin
      cycles(1);
      seen = seen | key_q.antenna_output_relay | key_q.drive_input_relay;
    end
    check1(seen, 1'b0, "relay closed with clock lost");
    drive_on = 1'b0;
    xtal_run = 1'b1;
    t = 0;
    while (clock_lost_q !== 1'b0 && t < 17000) begin
      cycles(1);
      t++;
    end
    check1(clock_lost_q, 1'b0, "monitor not cleared by gate pulses");
  endtask : t_loss

  // ==================================================================
  // main sequence
  initial begin
    n_fail    = 0;
    n_tests   = 0;
    reset     = 1'b1;
    drive_on  = 1'b0;
    reflected = 1'b0;
    xtal_run  = 1'b1;
    cycles(2);
    reset = 1'b0;
    cycles(1);
    t_reset();
    t_reflected();
    t_key();
    t_loss();
    tally_and_finish();
  end
endmodule : rfks_top_tb
`default_nettype wire

// file: rfks_xcvr_model.sv
// rfks_xcvr_model.sv: transceiver and crystal stand-in driving the rf keying block pins
`timescale 1ns/10ps
`default_nettype none
module rfks_xcvr_model (
  input  wire logic clk_sys,
  input  wire logic drive_on,
  input  wire logic reflected,
  input  wire logic xtal_run,
  output logic      rf_present,
  output logic      direction_forward,
  output logic      rf_sample,
  output logic      crystal_tick
);
  // ==================================================================
  // pin drive, launched on the falling edge
  logic phase;

  initial begin
    rf_present        = 1'b0;
    direction_forward = 1'b0;
    rf_sample         = 1'b0;
    crystal_tick      = 1'b0;
    phase             = 1'b0;
  end
  // each level of the fast lines holds two cycles, so the synchroniser's agreement test can see it
  // a stopped crystal freezes its line, which is how a dead oscillator looks
  always @(negedge clk_sys) begin
    phase             <= ~phase;
    rf_present        <= drive_on | reflected;
    direction_forward <= drive_on;
    if (phase) begin
      rf_sample <= (drive_on | reflected) ? ~rf_sample : 1'b0;
      if (xtal_run) begin
        crystal_tick <= ~crystal_tick;
      end
    end
  end
endmodule : rfks_xcvr_model
`default_nettype wire
